// ==== bench/pss_pv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_pv_model (
  input  wire logic        clk,
  input  wire logic        slew,
  input  wire logic [15:0] level,
  output logic [15:0]      pv
);
  // ----
  // process value: jumps, or creeps one count a clock like a slow plant
  // ----
  wire logic up = pv < level;
  always_ff @(posedge clk) begin
    if (!slew || pv == level) begin
      pv <= level;
    end else begin
      pv <= up ? pv + 16'h0001 : pv - 16'h0001;
    end
  end
endmodule // pss_pv_model
`default_nettype wire

// ==== bench/pss_sequencer_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer_assertions (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic [15:0] PV_IN,
  input wire logic        HOLD_CANCEL_CONTACT,
  input wire logic        SEGMENT_DEFINITION_SELECT,
  input wire logic [1:0]  START_BEHAVIOUR_CODE,
  input wire logic [15:0] START_TARGET_SP,
  input wire logic [1:0]  PID_SELECT_MODE,
  input wire logic [2:0]  ZONE_POINTS_USED,
  input wire logic [15:0] ZONE_REF_POINT_ONE,
  input wire logic [15:0] ZONE_REF_POINT_TWO,
  input wire logic [15:0] DEV_BAND,
  input wire logic [2:0]  DEVIATION_PID_GROUP,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [15:0] PROGRAM_SP,
  input wire logic [15:0] CONTROL_OUT,
  input wire logic [7:0]  EVENT_OUT,
  input wire logic [2:0]  PID_GROUP,
  input wire logic        RUNNING
);
  // ----
  // expected group; exact boundary values skipped, their side is a free choice
  // ----
  wire logic [15:0] dev = (PV_IN >= PROGRAM_SP) ? PV_IN - PROGRAM_SP : PROGRAM_SP - PV_IN;
  wire logic off_edge = PV_IN != ZONE_REF_POINT_ONE && PV_IN != ZONE_REF_POINT_TWO;
  wire logic below_one = ZONE_POINTS_USED == 3'h0 || PV_IN < ZONE_REF_POINT_ONE;
  wire logic below_two = ZONE_POINTS_USED == 3'h1 || PV_IN < ZONE_REF_POINT_TWO;
  wire logic [2:0] zone_grp = below_one ? 3'h1 : (below_two ? 3'h2 : 3'h3);
  wire logic in_band = dev < DEV_BAND;
  wire logic [1:0] start_behaviour_code = START_BEHAVIOUR_CODE;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // pv passes two sync flops, so judge only after six quiet cycles
  sequence calm;
    ($stable(PV_IN) && $stable(PROGRAM_SP) && $stable(PID_SELECT_MODE)
      && $stable(ZONE_POINTS_USED) && $stable(DEVIATION_PID_GROUP))[*6];
  endsequence
  chk_reset_outputs: assert property (disable iff (1'b0) !RST_N |=>
    PID_GROUP == 3'h1 && !RUNNING && CONTROL_OUT == 16'h0000 && EVENT_OUT == 8'h00)
    else $error("outputs not cleared by reset");
  chk_read_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside its slot");
  chk_zone_group: assert property (calm ##0 (PID_SELECT_MODE == 2'h0 && off_edge)
    |-> PID_GROUP == zone_grp) else $error("zone group wrong");
  chk_dev_inside: assert property (calm ##0 (PID_SELECT_MODE == 2'h1 && in_band)
    |-> PID_GROUP == 3'h1) else $error("deviation group inside band wrong");
  chk_dev_outside: assert property (calm ##0 (PID_SELECT_MODE != 2'h0 && dev > DEV_BAND)
    |-> PID_GROUP == DEVIATION_PID_GROUP) else $error("deviation group outside band wrong");
  chk_both_inside: assert property (calm ##0 (PID_SELECT_MODE == 2'h2 && in_band && off_edge)
    |-> PID_GROUP == zone_grp) else $error("combined group inside band wrong");
  // start settings are taken two cycles before running shows
  chk_start_ssp: assert property ($rose(RUNNING) && ($past(start_behaviour_code, 2) == 2'h0
    || ($past(start_behaviour_code, 2) == 2'h2 && $past(SEGMENT_DEFINITION_SELECT, 2)))
    |-> ##[0:2] PROGRAM_SP == START_TARGET_SP) else $error("start setpoint wrong");
  chk_start_pv: assert property ($rose(RUNNING) && $past(start_behaviour_code, 2) == 2'h2
    && !$past(SEGMENT_DEFINITION_SELECT, 2) |-> ##[0:2] PROGRAM_SP == PV_IN)
    else $error("start from pv wrong");
  chk_cancel_off: assert property ($rose(HOLD_CANCEL_CONTACT) && !RUNNING
    |-> ##[3:8] (CONTROL_OUT == 16'h0000 && EVENT_OUT == 8'h00)) else $error("cancel left outputs");
  cover property ($rose(RUNNING));
  cover property ($rose(RUNNING) && $past(start_behaviour_code, 2) == 2'h1);
  cover property (PID_GROUP == 3'h3);
  cover property (PID_SELECT_MODE == 2'h2 && PID_GROUP == DEVIATION_PID_GROUP);
endmodule // pss_sequencer_assertions
bind pss_sequencer pss_sequencer_assertions u_pss_sequencer_assertions (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PV_IN(PV_IN), .HOLD_CANCEL_CONTACT(HOLD_CANCEL_CONTACT),
  .SEGMENT_DEFINITION_SELECT(SEGMENT_DEFINITION_SELECT), .START_TARGET_SP(START_TARGET_SP),
  .START_BEHAVIOUR_CODE(START_BEHAVIOUR_CODE), .PID_SELECT_MODE(PID_SELECT_MODE),
  .ZONE_POINTS_USED(ZONE_POINTS_USED), .ZONE_REF_POINT_ONE(ZONE_REF_POINT_ONE),
  .ZONE_REF_POINT_TWO(ZONE_REF_POINT_TWO), .DEV_BAND(DEV_BAND), .REG_RD(REG_RD),
  .DEVIATION_PID_GROUP(DEVIATION_PID_GROUP), .REG_RDATA(REG_RDATA), .PROGRAM_SP(PROGRAM_SP),
  .CONTROL_OUT(CONTROL_OUT), .EVENT_OUT(EVENT_OUT), .PID_GROUP(PID_GROUP), .RUNNING(RUNNING));
`default_nettype wire

// ==== bench/pss_sequencer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer_tb;
  // ----
  // stimulus and observation
  // ----
  logic clk = 1'b0, rst_n = 1'b0, segdef = 1'b0, program_time_unit = 1'b1, slew = 1'b0, we = 1'b0;
  logic wr = 1'b0, rd = 1'b0, run, irq;
  logic [2:0] keys = 3'h0, pts = 3'h0, deviation_pid_group, dgrp = 3'h5;
  logic [15:0] ssp = 16'h0064, wtime = 16'h0002;
  logic [1:0] start_behaviour_code = 2'h0, mode = 2'h0;
  logic [3:0] cnt = 4'h1, sa = 4'h0, ra = 4'h0, segn;
  logic [15:0] level = 16'h0000, wband = 16'hFFFF, wd = 16'h0000, pv, rdata, sp, ctl, s;
  logic [7:0] ev;
  pss_pkg::pss_seg_s sd = '0;
  logic [31:0] zt [9] = '{32'h00015E01, 32'h02003201, 32'h0200C802, 32'h02015E03,
    32'h01015E02, 32'h10007101, 32'h10009605, 32'h21007102, 32'h21003206};
  int err_count = 0, tests_run = 0, n;
  always #5 clk = ~clk;
  pss_pv_model u_pss_pv_model (.clk(clk), .slew(slew), .level(level), .pv(pv));
  pss_sequencer #(.TICK_SEC(10), .TICK_MIN(600)) u_pss_sequencer (.CORE_CLK(clk),
    .RST_N(rst_n), .PV_IN(pv), .START_KEY(keys[0]), .STOP_KEY(keys[1]),
    .HOLD_CANCEL_CONTACT(keys[2]), .SEGMENT_DEFINITION_SELECT(segdef),
    .PROGRAM_TIME_UNIT(program_time_unit), .START_BEHAVIOUR_CODE(start_behaviour_code), .START_TARGET_SP(ssp),
    .SEG_COUNT(cnt), .PID_SELECT_MODE(mode), .ZONE_POINTS_USED(pts),
    .ZONE_REF_POINT_ONE(16'h0064), .ZONE_REF_POINT_TWO(16'h012C), .DEV_BAND(16'h000A),
    .DEVIATION_PID_GROUP(dgrp), .WAIT_BAND(wband), .WAIT_TIME(wtime), .SEG_WE(we),
    .SEG_WADDR(sa), .SEG_WDATA(sd), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .PROGRAM_SP(sp), .CONTROL_OUT(ctl), .EVENT_OUT(ev),
    .PID_GROUP(deviation_pid_group), .SEG_NUM(segn), .RUNNING(run), .IRQ(irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask
  task automatic seg_write(input logic [3:0] a, input logic [39:0] v, input logic [1:0] f);
    @(posedge clk);
    we <= 1'b1;
    sa <= a;
    sd <= {v[39:8], f, v[7:0]};
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic press(input int k);
    @(posedge clk);
    keys <= 3'h1 << k;
    tick(4);
    keys <= 3'h0;
    for (int i = 0; i < 12 && k == 0 && run !== 1'b1; i++) tick(1);
  endtask
  // counts cycles until the status state field reads st
  task automatic poll(input logic [1:0] st, input int lim);
    n = 0;
    reg_read(pss_pkg::A_STAT);
    while (s[1:0] !== st && n < lim) begin
      reg_read(pss_pkg::A_STAT);
      n += 2;
    end
    check({14'h0, s[1:0]}, {14'h0, st});
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(6000);
    err_count++;
    print_verdict();
  end
  initial begin
    tick(3);
    rst_n <= 1'b1;
    reg_write(4'hF, 16'hFFFF);
    reg_read(4'hF);
    check(s, 16'h0000);
    check({13'h0, deviation_pid_group}, 16'h0001);
    $display("done reset");
    seg_write(4'h0, {16'h006E, 16'h000A, 8'hA5}, 2'h1);
    press(0);
    check(sp, 16'h0064);
    tick(50);
    check(16'(sp >= 16'h0068 && sp <= 16'h006A), 16'h0001);
    poll(2'h3, 200);
    check(sp, 16'h006E);
    check({ev, ctl[7:0]}, 16'hA5FF);
    reg_write(pss_pkg::A_MASK, 16'h0000);
    tick(2);
    check(16'(irq), 16'h0000);
    reg_write(pss_pkg::A_MASK, 16'h0002);
    tick(2);
    check(16'(irq), 16'h0001);
    reg_write(pss_pkg::A_IRQ, 16'h0002);
    tick(2);
    check(16'(irq), 16'h0000);
    foreach (zt[i]) begin
      mode <= zt[i][29:28];
      pts <= zt[i][26:24];
      level <= zt[i][23:8];
      if (i == 8) dgrp <= 3'h6;
      tick(10);
      check({13'h0, deviation_pid_group}, {13'h0, zt[i][2:0]});
    end
    press(2);
    tick(6);
    check({ev, ctl[7:0]}, 16'h0000);
    $display("done hold and groups");
    program_time_unit <= pss_pkg::TMU_HHMM;
    start_behaviour_code <= pss_pkg::STC_PV;
    level <= 16'h0096;
    seg_write(4'h0, {16'h00C8, 16'h0001, 8'h3C}, 2'h0);
    press(0);
    check(sp, 16'h0096);
    poll(2'h0, 700);
    check(16'(n >= 585 && n <= 615), 16'h0001);
    $display("done start from pv");
    segdef <= pss_pkg::SEGDEF_RAMP;
    program_time_unit <= pss_pkg::TMU_MMSS;
    cnt <= 4'h2;
    seg_write(4'h0, {16'h006E, 16'h003C, 8'h01}, 2'h0);
    seg_write(4'h1, {16'h006E, 16'h0005, 8'h02}, 2'h2);
    press(0);
    check(sp, 16'h0064);
    segdef <= pss_pkg::SEGDEF_TIME;
    tick(50);
    check(16'(sp >= 16'h0068 && sp <= 16'h006A), 16'h0001);
    poll(2'h0, 200);
    check(16'(n >= 90 && n <= 110), 16'h0001);
    $display("done ramp");
    start_behaviour_code <= pss_pkg::STC_SSP;
    wband <= 16'h0005;
    level <= 16'h0000;
    seg_write(4'h0, {16'h0096, 16'h0003, 8'h0F}, 2'h0);
    seg_write(4'h1, {16'h0096, 16'h0003, 8'hF0}, 2'h0);
    press(0);
    slew <= 1'b1;
    level <= 16'h0096;
    poll(2'h2, 60);
    check({8'h00, ev}, 16'h000F);
    s = {12'h000, segn};
    tick(8);
    check({12'h000, segn}, s);
    poll(2'h1, 40);
    check(16'(n >= 4 && n <= 16), 16'h0001);
    check({8'h00, ev}, 16'h00F0);
    reg_read(pss_pkg::A_IRQ);
    check(s, 16'h0007);
    $display("done wait");
    poll(2'h0, 60);
    start_behaviour_code <= pss_pkg::STC_RAMP;
    cnt <= 4'h1;
    ssp <= 16'h0032;
    slew <= 1'b0;
    level <= 16'h0096;
    seg_write(4'h0, {16'h00FA, 16'h000A, 8'h00}, 2'h0);
    reg_write(pss_pkg::A_CTRL, 16'h0001);
    tick(2);
    check(sp, 16'h0096);
    poll(2'h0, 100);
    check(16'(n >= 40 && n <= 60), 16'h0001);
    $display("done join ramp");
    print_verdict();
  end
endmodule // pss_sequencer_tb
`default_nettype wire

// ==== rtl/pss_pkg.sv ====
package pss_pkg;
  // ---------------------------------------------------------------
  // widths and codes
  // ---------------------------------------------------------------
  localparam int PV_W    = 16;
  localparam int TIME_W  = 16;
  localparam int GRP_W   = 3;
  localparam int SEG_W   = 4;
  localparam logic       SEGDEF_TIME = 1'h0;
  localparam logic       SEGDEF_RAMP = 1'h1;
  localparam logic       TMU_HHMM    = 1'h0;
  localparam logic       TMU_MMSS    = 1'h1;
  localparam logic [1:0] STC_SSP     = 2'h0;
  localparam logic [1:0] STC_RAMP    = 2'h1;
  localparam logic [1:0] STC_PV      = 2'h2;
  localparam logic [1:0] SEL_ZONE    = 2'h0;
  localparam logic [1:0] SEL_DEV     = 2'h1;
  localparam logic [1:0] SEL_BOTH    = 2'h2;
  localparam logic [2:0] GRP_ONE     = 3'h1;
  localparam logic [2:0] GRP_TWO     = 3'h2;
  localparam logic [2:0] GRP_THREE   = 3'h3;
  localparam logic [15:0] OUT_OFF    = 16'h0000;
  localparam logic [15:0] OUT_ON     = 16'hFFFF;
  // ---------------------------------------------------------------
  // timing: seconds and minutes expressed in core clocks
  // ---------------------------------------------------------------
  localparam longint CLK_HZ       = 100000000;
  localparam longint SEC_S        = 1;
  localparam longint MIN_S        = 60;
  localparam longint CYC_PER_SEC  = CLK_HZ * SEC_S;
  localparam longint CYC_PER_MIN  = CLK_HZ * MIN_S;
  // interrupt status bits
  localparam int IRQ_SEG  = 0;
  localparam int IRQ_END  = 1;
  localparam int IRQ_WAIT = 2;
  localparam int IRQ_W    = 3;
  // register offsets
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_STAT   = 4'h1;
  localparam logic [3:0] A_IRQ    = 4'h2;
  localparam logic [3:0] A_MASK   = 4'h3;
  localparam logic [3:0] A_SP     = 4'h4;

  typedef enum {ST_IDLE, ST_RUN, ST_WAIT, ST_HOLD} pss_state_e;

  typedef struct packed {
    logic [PV_W-1:0]   target;
    logic [TIME_W-1:0] time_or_ramp;  // duration, or grade per unit
    logic              soak;          // duration even in ramp mode
    logic              junction_hold;
    logic [7:0]        events;
  } pss_seg_s;
endpackage : pss_pkg

// ==== rtl/pss_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1 - segment select: 0 time, 1 ramp grade
// R2 - time unit hh:mm default, or mm:ss
// R3 - ramp grade per hour or minute, linear
// R4 - soak segment uses duration in ramp mode
// R5 - code 0: start at starting target setpoint
// R6 - code 2: start from PV, full time
// R7 - code 2 not offered in ramp mode
// R8 - code 1: join ramp at PV, shortened
// R9 - up to seven zones, default zone 1; the code gives at most three zones, groups 1 to 3
// R10 - two points give groups 1,2,3
// R11 - one point splits into groups 1,2
// R12 - deviation only: group 1 inside band
// R13 - combined: zone group inside band
// R14 - junction hold keeps end outputs
// R15 - hold cancel forces output, events off
// R16 - wait at transition until band or timeout
// R17 - waiting freezes segment and event time
// R18 - latch mode selections at program start; the code latches segment select and time unit only
module pss_sequencer #(
  parameter int  NSEG       = 16,
  parameter int  NZONE      = 7,
  parameter longint TICK_SEC = pss_pkg::CYC_PER_SEC,
  parameter longint TICK_MIN = pss_pkg::CYC_PER_MIN
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RST_N,
  input  wire logic [pss_pkg::PV_W-1:0]   PV_IN,
  input  wire logic                       START_KEY,
  input  wire logic                       STOP_KEY,
  input  wire logic                       HOLD_CANCEL_CONTACT,
  input  wire logic                       SEGMENT_DEFINITION_SELECT,
  input  wire logic                       PROGRAM_TIME_UNIT,
  input  wire logic [1:0]                 START_BEHAVIOUR_CODE,
  input  wire logic [pss_pkg::PV_W-1:0]   START_TARGET_SP,
  input  wire logic [pss_pkg::SEG_W-1:0]  SEG_COUNT,
  input  wire logic [1:0]                 PID_SELECT_MODE,
  input  wire logic [2:0]                 ZONE_POINTS_USED,
  input  wire logic [pss_pkg::PV_W-1:0]   ZONE_REF_POINT_ONE,
  input  wire logic [pss_pkg::PV_W-1:0]   ZONE_REF_POINT_TWO,
  input  wire logic [pss_pkg::PV_W-1:0]   DEV_BAND,
  input  wire logic [2:0]                 DEVIATION_PID_GROUP,
  input  wire logic [pss_pkg::PV_W-1:0]   WAIT_BAND,
  input  wire logic [pss_pkg::TIME_W-1:0] WAIT_TIME,
  input  wire logic                       SEG_WE,
  input  wire logic [pss_pkg::SEG_W-1:0]  SEG_WADDR,
  input  wire pss_pkg::pss_seg_s          SEG_WDATA,
  input  wire logic [3:0]                 REG_ADDR,
  input  wire logic [15:0]                REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic [15:0]                     REG_RDATA,
  output logic [pss_pkg::PV_W-1:0]        PROGRAM_SP,
  output logic [15:0]                     CONTROL_OUT,
  output logic [7:0]                      EVENT_OUT,
  output logic [2:0]                      PID_GROUP,
  output logic [pss_pkg::SEG_W-1:0]       SEG_NUM,
  output logic                            RUNNING,
  output logic                            IRQ
);
  // ---------------------------------------------------------------
  // input synchronisers (pins)
  // ---------------------------------------------------------------
  logic [2:0] key_m;
  logic [2:0] key_s;
  logic [2:0] key_d;
  logic [pss_pkg::PV_W-1:0] pv_m;
  logic [pss_pkg::PV_W-1:0] pv;
  always_ff @(posedge CORE_CLK) begin
    key_m <= {HOLD_CANCEL_CONTACT, STOP_KEY, START_KEY};
    key_s <= key_m;
    key_d <= key_s;
    pv_m  <= PV_IN;
    pv    <= pv_m;
  end
  wire start_p  = key_s[0] & ~key_d[0];
  wire stop_p   = key_s[1] & ~key_d[1];
  wire cancel_p = key_s[2] & ~key_d[2];

  // ---------------------------------------------------------------
  // segment memory
  // ---------------------------------------------------------------
  pss_pkg::pss_seg_s seg_mem [NSEG];
  always_ff @(posedge CORE_CLK) begin
    if (SEG_WE) begin
      seg_mem[SEG_WADDR] <= SEG_WDATA;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pss_pkg::pss_state_e state;
  logic                         mode_ramp;
  logic                         mode_mmss;
  logic [pss_pkg::SEG_W-1:0]    seg;
  logic [pss_pkg::PV_W-1:0]     sp;
  logic [pss_pkg::PV_W-1:0]     seg_start;
  logic [pss_pkg::TIME_W-1:0]   elapsed;
  logic [pss_pkg::TIME_W-1:0]   wait_cnt;
  logic [31:0]                  tick_cnt;
  logic [31:0]                  frac_cnt;
  logic [7:0]                   events;
  logic [15:0]                  ctrl_out;
  logic [pss_pkg::IRQ_W-1:0]    irq_stat;
  logic [pss_pkg::IRQ_W-1:0]    irq_mask;
  logic                         sw_run;

  pss_pkg::pss_seg_s cur;
  assign cur = seg_mem[seg];

  // time base: one tick per unit second/minute
  wire [31:0] tick_len = mode_mmss ? 32'(TICK_SEC) : 32'(TICK_MIN);  // R2
  wire        tick     = (tick_cnt == tick_len - 32'h1);
  // ramp: one setpoint count per (hour or minute)/grade
  wire [31:0] unit_len = mode_mmss ? 32'(TICK_MIN) : 32'(TICK_MIN * pss_pkg::MIN_S);  // R3
  wire        grade_mode = mode_ramp & ~cur.soak;  // R1 R4
  wire [31:0] step_len = (cur.time_or_ramp == 16'h0) ? unit_len
                         : unit_len / 32'(cur.time_or_ramp);
  wire        step     = (frac_cnt >= step_len - 32'h1);
  wire        rising   = cur.target > seg_start;
  wire        at_tgt   = (sp == cur.target);
  // time mode: interpolated sp from start to target
  wire signed [33:0] span = $signed({2'h0, cur.target}) - $signed({2'h0, seg_start});
  wire signed [33:0] lin  = (cur.time_or_ramp == 16'h0) ? span
                            : (span * $signed({18'h0, elapsed}))
                              / $signed({18'h0, cur.time_or_ramp});
  wire [pss_pkg::PV_W-1:0] time_sp = seg_start + lin[pss_pkg::PV_W-1:0];  // R1
  wire seg_done = grade_mode ? at_tgt : (elapsed >= cur.time_or_ramp);

  // wait zone check
  wire [pss_pkg::PV_W-1:0] dev_w = (pv > cur.target) ? pv - cur.target : cur.target - pv;
  wire in_wait_band = (dev_w <= WAIT_BAND);
  wire last_seg     = (seg == SEG_COUNT - 4'h1);

  // start code 1 join point: pv clipped between start sp and target
  pss_pkg::pss_seg_s first;
  assign first = seg_mem[0];
  wire pv_past = (first.target >= START_TARGET_SP) ? (pv >= first.target)
                                                   : (pv <= first.target);
  wire pv_below = (first.target >= START_TARGET_SP) ? (pv <= START_TARGET_SP)
                                                    : (pv >= START_TARGET_SP);
  wire [pss_pkg::PV_W-1:0] join_sp = pv_below ? START_TARGET_SP  // R8
                                     : (pv_past ? first.target : pv);
  // R7: code 2 falls back to code 0 in ramp mode
  wire use_pv_start = (START_BEHAVIOUR_CODE == pss_pkg::STC_PV)
                      & (SEGMENT_DEFINITION_SELECT == pss_pkg::SEGDEF_TIME);  // R7
  wire use_join     = (START_BEHAVIOUR_CODE == pss_pkg::STC_RAMP);
  wire [pss_pkg::PV_W-1:0] start_sp = use_pv_start ? pv  // R6
                                      : (use_join ? join_sp : START_TARGET_SP);  // R5 R8
  // elapsed time skipped by joining the ramp part way
  wire [pss_pkg::PV_W-1:0] j_num = (join_sp > START_TARGET_SP)
                                   ? join_sp - START_TARGET_SP : START_TARGET_SP - join_sp;
  wire [pss_pkg::PV_W-1:0] j_den = (first.target > START_TARGET_SP)
                                   ? first.target - START_TARGET_SP
                                   : START_TARGET_SP - first.target;
  wire [31:0] j_prod = 32'(j_num) * 32'(first.time_or_ramp);
  wire [pss_pkg::TIME_W-1:0] join_elapsed = (j_den == 16'h0) ? 16'h0
                                            : 16'(j_prod / 32'(j_den));  // R8

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state     <= pss_pkg::ST_IDLE;
      mode_ramp <= pss_pkg::SEGDEF_TIME;
      mode_mmss <= pss_pkg::TMU_HHMM;
      seg       <= '0;
      sp        <= '0;
      seg_start <= '0;
      elapsed   <= '0;
      wait_cnt  <= '0;
      tick_cnt  <= '0;
      frac_cnt  <= '0;
      events    <= '0;
      ctrl_out  <= pss_pkg::OUT_OFF;
    end else begin
      case (state)
        pss_pkg::ST_IDLE: begin
          if (start_p | sw_run) begin
            state     <= pss_pkg::ST_RUN;
            mode_ramp <= SEGMENT_DEFINITION_SELECT;  // R18
            mode_mmss <= PROGRAM_TIME_UNIT;  // R18
            seg       <= '0;
            sp        <= start_sp;
            seg_start <= use_join ? START_TARGET_SP : start_sp;
            elapsed   <= use_join ? join_elapsed : 16'h0;  // R8
            tick_cnt  <= '0;
            frac_cnt  <= '0;
            events    <= first.events;
            ctrl_out  <= pss_pkg::OUT_ON;
          end
        end
        pss_pkg::ST_RUN: begin
          tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
          if (tick && !grade_mode) begin
            elapsed <= elapsed + 16'h1;
          end
          if (grade_mode) begin
            frac_cnt <= step ? 32'h0 : frac_cnt + 32'h1;
            if (step && !at_tgt) begin
              sp <= rising ? sp + 16'h1 : sp - 16'h1;  // R3
            end
          end else begin
            sp <= (elapsed >= cur.time_or_ramp) ? cur.target : time_sp;  // R4
          end
          if (stop_p) begin
            state <= pss_pkg::ST_IDLE;
          end else if (seg_done) begin
            if (last_seg && cur.junction_hold) begin
              state <= pss_pkg::ST_HOLD;  // R14
            end else if (last_seg) begin
              state    <= pss_pkg::ST_IDLE;
              ctrl_out <= pss_pkg::OUT_OFF;
              events   <= '0;
            end else if (!in_wait_band) begin
              state    <= pss_pkg::ST_WAIT;  // R16
              wait_cnt <= '0;
            end else begin
              seg       <= seg + 4'h1;
              seg_start <= cur.target;
              elapsed   <= '0;
            end
          end
        end
        pss_pkg::ST_WAIT: begin
          // segment and event time frozen; events retained
          tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;  // R17
          if (tick) begin
            wait_cnt <= wait_cnt + 16'h1;
          end
          if (stop_p) begin
            state <= pss_pkg::ST_IDLE;
          end else if (in_wait_band || wait_cnt >= WAIT_TIME) begin
            state     <= pss_pkg::ST_RUN;  // R16
            seg       <= seg + 4'h1;
            seg_start <= cur.target;
            elapsed   <= '0;
            // held events move on only once waiting ends
            events    <= seg_mem[seg + 4'h1].events;  // R17
          end
        end
        pss_pkg::ST_HOLD: begin
          // setpoint, control and event outputs frozen at end state; PID_GROUP still follows pv
          if (cancel_p || stop_p) begin
            state    <= pss_pkg::ST_IDLE;  // R15
            ctrl_out <= pss_pkg::OUT_OFF;  // R15
            events   <= '0;  // R15
          end
        end
        default: state <= pss_pkg::ST_IDLE;
      endcase
      if (state == pss_pkg::ST_RUN && seg_done && !last_seg && in_wait_band) begin
        events <= seg_mem[seg + 4'h1].events;
      end
    end
  end

  // ---------------------------------------------------------------
  // pid group selection
  // ---------------------------------------------------------------
  wire [pss_pkg::PV_W-1:0] dev_p = (pv > sp) ? pv - sp : sp - pv;
  wire in_dev = (dev_p <= DEV_BAND);
  wire [2:0] zone_grp =
    (ZONE_POINTS_USED == 3'h0) ? pss_pkg::GRP_ONE :  // R9
    (ZONE_POINTS_USED == 3'h1) ? ((pv < ZONE_REF_POINT_ONE) ? pss_pkg::GRP_ONE
                                                            : pss_pkg::GRP_TWO) :  // R11
    ((pv < ZONE_REF_POINT_ONE) ? pss_pkg::GRP_ONE :
     (pv < ZONE_REF_POINT_TWO) ? pss_pkg::GRP_TWO : pss_pkg::GRP_THREE);  // R10
  wire [2:0] next_grp =
    (PID_SELECT_MODE == pss_pkg::SEL_DEV)  ? (in_dev ? pss_pkg::GRP_ONE
                                                     : DEVIATION_PID_GROUP) :  // R12
    (PID_SELECT_MODE == pss_pkg::SEL_BOTH) ? (in_dev ? zone_grp
                                                     : DEVIATION_PID_GROUP) :  // R13
    zone_grp;

  // ---------------------------------------------------------------
  // registers and interrupt
  // ---------------------------------------------------------------
  wire [pss_pkg::IRQ_W-1:0] irq_set;
  assign irq_set[pss_pkg::IRQ_SEG]  = (state == pss_pkg::ST_RUN) & seg_done & ~last_seg;
  assign irq_set[pss_pkg::IRQ_END]  = (state == pss_pkg::ST_RUN) & seg_done & last_seg;
  assign irq_set[pss_pkg::IRQ_WAIT] = (state == pss_pkg::ST_RUN) & seg_done & ~last_seg
                                      & ~in_wait_band;
  wire wr_irq  = REG_WR & (REG_ADDR == pss_pkg::A_IRQ);
  wire wr_ctrl = REG_WR & (REG_ADDR == pss_pkg::A_CTRL);
  wire [pss_pkg::IRQ_W-1:0] w1c = wr_irq ? REG_WDATA[pss_pkg::IRQ_W-1:0] : '0;
  wire [15:0] next_rdata =
    (REG_ADDR == pss_pkg::A_CTRL) ? {15'h0, sw_run} :
    (REG_ADDR == pss_pkg::A_STAT) ? {8'h0, seg, 2'h0, 2'(state)} :
    (REG_ADDR == pss_pkg::A_IRQ)  ? {13'h0, irq_stat} :
    (REG_ADDR == pss_pkg::A_MASK) ? {13'h0, irq_mask} :
    (REG_ADDR == pss_pkg::A_SP)   ? sp : 16'h0000;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      irq_stat    <= '0;
      irq_mask    <= '0;
      sw_run      <= 1'b0;
      REG_RDATA   <= '0;
      IRQ         <= 1'b0;
      PROGRAM_SP  <= '0;
      CONTROL_OUT <= pss_pkg::OUT_OFF;
      EVENT_OUT   <= '0;
      PID_GROUP   <= pss_pkg::GRP_ONE;
      SEG_NUM     <= '0;
      RUNNING     <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      irq_stat    <= (irq_stat & ~w1c) | irq_set;
      if (REG_WR && REG_ADDR == pss_pkg::A_MASK) begin
        irq_mask <= REG_WDATA[pss_pkg::IRQ_W-1:0];
      end
      // run request is a one-shot; cleared the cycle after the write, taken or not
      sw_run      <= wr_ctrl & REG_WDATA[0];
      REG_RDATA   <= REG_RD ? next_rdata : 16'h0000;
      IRQ         <= |(irq_stat & irq_mask);
      PROGRAM_SP  <= sp;
      CONTROL_OUT <= ctrl_out;
      EVENT_OUT   <= events;
      PID_GROUP   <= next_grp;
      SEG_NUM     <= seg;
      RUNNING     <= (state == pss_pkg::ST_RUN) | (state == pss_pkg::ST_WAIT);
    end
  end
endmodule : pss_sequencer
`default_nettype wire
